// >>> common/upwc_pkg.sv
package upwc_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_TIMEOUT = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h8;

  // control register fields
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_VAR_LSB     = 4;
  localparam int CTRL_FLOW_BIT    = 8;
  localparam int CTRL_DACT_LSB    = 12;

  // status register fields
  localparam int STAT_PORT_BIT    = 0;
  localparam int STAT_CTS_BIT     = 1;
  localparam int STAT_STATE_LSB   = 2;
  localparam int STAT_REJECT_BIT  = 4;
  localparam int STAT_DISCARD_BIT = 5;

  // power-save mode selector values
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_RTS     = 3'h2;
  localparam logic [2:0] MODE_DTR     = 3'h3;
  localparam logic [2:0] MODE_TIMEO2  = 3'h4;
  localparam logic [2:0] MODE_MAX     = 3'h4;
  localparam logic [2:0] VAR_SINGLE_MAX = 3'h1;
  localparam logic [2:0] VAR_MAX        = 3'h4;

  localparam logic [2:0]  MODE_RST    = 3'h0;
  localparam logic [2:0]  VAR_RST     = 3'h0;
  localparam logic [1:0]  DACT_RST    = 2'h0;
  localparam logic [15:0] TIMEOUT_RST = 16'h07d0;

  // timing
  localparam longint CLK_HZ      = 100_000_000;
  localparam longint WAKE_MS     = 15;
  localparam int     WAKE_CYC    = int'(WAKE_MS * CLK_HZ / 1000);
  localparam longint FRAME_US    = 1000;
  localparam int     FRAME_CYC   = int'(FRAME_US * CLK_HZ / 1_000_000);
  localparam int     WAKE_W      = 24;
  localparam int     DIV_W       = 24;
  localparam logic [WAKE_W-1:0] WAKE_ONE = 24'h000001;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_IDLE   = 2'b01,
    ST_WAKING = 2'b11,
    ST_DEEP   = 2'b10
  } upwc_state_t;

  // host-driven control lines, all active when on
  typedef struct packed {
    logic dtr_on;
    logic rts_on;
    logic txd;
  } upwc_lines_t;

endpackage

// >>> core/upwc_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module upwc_tick_div #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clr_i,
  output logic      tick_o
);

  localparam logic [upwc_pkg::DIV_W-1:0] LAST = upwc_pkg::DIV_W'(DIV - 1);

  logic [upwc_pkg::DIV_W-1:0] cnt_r;
  wire                        wrap = (cnt_r == LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i || wrap) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap && !clr_i;
    end
  end

endmodule
`default_nettype wire

// >>> core/upwc_top.sv
// Overview of operation
// - dtr-gated mode 3 accepted only with single-port variant 0 or 1.
// - mode 3, dtr going off disables the port at once.
// - mode 3 with dtr off, port reopens while device has its own data.
// - mode 3, dtr rising reopens port; idle device becomes active 15 ms later.
// - mode 3 with dtr on: no idle, no deep sleep, port stays enabled.
// - mode 3, dtr changes still raise the configured dtr action event.
// - with flow control in mode 3, cts follows port enable.
// - deep sleep: port dead, received data ignored, nothing sent.
// - idle, txd off-to-on wakes; port stays disabled until active unless device has its own data, within 15 ms.
// - wake character discarded; characters accepted only after wake completes.
// - wake on received data armed in modes 1 and 4.
// - no data wake in mode 2 with rts off or mode 3 dtr off.
// - timeout modes disable port after configured frames without received data.
// - wake on received data has no disable setting.
// - every received character restarts the idle timer.
// - mode 2 needs flow control off; rts off disables port at once.
`timescale 1ns/1ps
`default_nettype none
module upwc_top #(
  parameter int unsigned FRAME_CYCLES = upwc_pkg::FRAME_CYC,
  parameter int unsigned WAKE_CYCLES  = upwc_pkg::WAKE_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone classic slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // host lines and device side
  input  wire upwc_pkg::upwc_lines_t lines_i,
  input  wire logic                  rx_char_i,
  input  wire logic                  tx_pending_i,
  input  wire logic                  deep_req_i,
  output logic                       port_en_o,
  output logic                       cts_on_o,
  output logic                       rx_accept_o,
  output logic                       tx_allow_o,
  output logic                       active_o,
  output logic                       deep_sleep_o,
  output logic                       dtr_evt_o,
  output logic                       dtr_evt_on_o,
  output logic      [1:0]            dtr_action_o
);

  localparam logic [upwc_pkg::WAKE_W-1:0] WAKE_LAST =
    upwc_pkg::WAKE_W'(WAKE_CYCLES - 1);

  // configuration
  logic [2:0]  mode_r;
  logic [2:0]  variant_r;
  logic        flow_en_r;
  logic [1:0]  dact_r;
  logic [15:0] timeout_r;
  logic        reject_r;
  logic        discard_r;

  // state
  upwc_pkg::upwc_state_t       state_r;
  upwc_pkg::upwc_state_t       state_nxt;
  upwc_pkg::upwc_lines_t       lines_prev_r;
  logic [15:0] frames_r;
  logic [upwc_pkg::WAKE_W-1:0] wake_cnt_r;
  logic        frame_tick;

  // bus decode
  // ack blocks a second take while the master still holds its strobe
  wire         bus_req   = cyc_i && stb_i && !ack_o;
  wire         wr_ctrl   = bus_req && we_i && (adr_i == upwc_pkg::REG_CTRL);
  wire         wr_tmo    = bus_req && we_i && (adr_i == upwc_pkg::REG_TIMEOUT);
  wire         wr_stat   = bus_req && we_i && (adr_i == upwc_pkg::REG_STATUS);

  wire [2:0]   new_mode  = dat_i[upwc_pkg::CTRL_MODE_LSB +: 3];
  wire [2:0]   new_var   = dat_i[upwc_pkg::CTRL_VAR_LSB +: 3];
  wire         new_flow  = dat_i[upwc_pkg::CTRL_FLOW_BIT];
  wire [1:0]   new_dact  = dat_i[upwc_pkg::CTRL_DACT_LSB +: 2];

  // a rejected write leaves the old setting whole rather than half-applied
  wire         ctrl_ok   = (new_mode <= upwc_pkg::MODE_MAX)
                        && (new_var <= upwc_pkg::VAR_MAX)
                        && !(new_mode == upwc_pkg::MODE_DTR
                             && new_var > upwc_pkg::VAR_SINGLE_MAX)
                        && !(new_mode == upwc_pkg::MODE_RTS && new_flow);
  wire         ctrl_take = wr_ctrl && sel_i[0] && sel_i[1] && ctrl_ok;
  wire         ctrl_bad  = wr_ctrl && sel_i[0] && sel_i[1] && !ctrl_ok;

  // mode decode
  wire         m_off     = (mode_r == upwc_pkg::MODE_OFF);
  wire         m_rts     = (mode_r == upwc_pkg::MODE_RTS);
  wire         m_dtr     = (mode_r == upwc_pkg::MODE_DTR);
  wire         gated     = m_rts || m_dtr;
  wire         gate_on   = m_rts ? lines_i.rts_on : lines_i.dtr_on;
  wire         gate_off  = gated && !gate_on;
  // no config bit can clear this arm; only the mode itself selects it
  wire         wake_arm  = (mode_r == upwc_pkg::MODE_TIMEOUT)
                        || (mode_r == upwc_pkg::MODE_TIMEO2);
  wire         txd_fall  = lines_prev_r.txd && !lines_i.txd;
  wire         data_wake = wake_arm && txd_fall;
  wire         dtr_chg   = lines_prev_r.dtr_on != lines_i.dtr_on;
  wire         wake_done = (wake_cnt_r == WAKE_LAST);
  wire         timed_out = wake_arm && (frames_r >= timeout_r);

  // next power state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      upwc_pkg::ST_ACTIVE: begin
        if (m_off) begin
          state_nxt = upwc_pkg::ST_ACTIVE;
        end else if (gate_off && !tx_pending_i) begin
          state_nxt = upwc_pkg::ST_IDLE;
        end else if (timed_out && !tx_pending_i) begin
          state_nxt = upwc_pkg::ST_IDLE;
        end
      end
      upwc_pkg::ST_IDLE: begin
        if (m_off || tx_pending_i) begin
          state_nxt = upwc_pkg::ST_ACTIVE;
        end else if (gated && gate_on) begin
          state_nxt = upwc_pkg::ST_WAKING;
        end else if (data_wake) begin
          state_nxt = upwc_pkg::ST_WAKING;
        end else if (deep_req_i) begin
          state_nxt = upwc_pkg::ST_DEEP;
        end
      end
      upwc_pkg::ST_WAKING: begin
        if (m_off) begin
          state_nxt = upwc_pkg::ST_ACTIVE;
        end else if (gate_off) begin
          state_nxt = upwc_pkg::ST_IDLE;
        end else if (wake_done) begin
          state_nxt = upwc_pkg::ST_ACTIVE;
        end
      end
      upwc_pkg::ST_DEEP: begin
        if (m_off || (gated && gate_on)) begin
          state_nxt = upwc_pkg::ST_WAKING;
        end else if (!deep_req_i) begin
          state_nxt = upwc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // port enable and receive acceptance for the next cycle
  wire nxt_active = (state_nxt == upwc_pkg::ST_ACTIVE);
  wire nxt_waking = (state_nxt == upwc_pkg::ST_WAKING);
  wire in_deep   = (state_nxt == upwc_pkg::ST_DEEP);
  wire port_nxt  = m_off
                || nxt_active
                || (nxt_waking && gated)
                || (tx_pending_i && !in_deep);
  // the wake character and anything before wake completes is dropped;
  // mode 0 leaving deep sleep spends one cycle waking, not the whole wake time
  wire acc_nxt   = port_nxt && !in_deep
                && nxt_active
                && !gate_off;
  wire cts_nxt   = flow_en_r ? port_nxt : 1'b1;

  // previous lines start low, so an idle-high txd gives no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= upwc_pkg::ST_ACTIVE;
      lines_prev_r <= '0;
    end else begin
      state_r      <= state_nxt;
      lines_prev_r <= lines_i;
    end
  end

  // idle timer in frames, restarted by every received character
  wire frames_clr = rx_char_i || (state_r != upwc_pkg::ST_ACTIVE);
  always_ff @(posedge clk_i) begin
    if (rst_i || frames_clr) begin
      frames_r <= '0;
    end else if (frame_tick && !timed_out) begin
      frames_r <= frames_r + 1'b1;
    end
  end

  upwc_tick_div #(
    .DIV (FRAME_CYCLES)
  ) u_frame_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (frames_clr),
    .tick_o (frame_tick)
  );

  // wake-up time counter
  // holds at its last value so a long stay cannot wrap to a false start
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != upwc_pkg::ST_WAKING) begin
      wake_cnt_r <= '0;
    end else if (!wake_done) begin
      wake_cnt_r <= wake_cnt_r + upwc_pkg::WAKE_ONE;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r    <= upwc_pkg::MODE_RST;
      variant_r <= upwc_pkg::VAR_RST;
      flow_en_r <= 1'b0;
      dact_r    <= upwc_pkg::DACT_RST;
    end else if (ctrl_take) begin
      mode_r    <= new_mode;
      variant_r <= new_var;
      flow_en_r <= new_flow;
      dact_r    <= new_dact;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_r <= upwc_pkg::TIMEOUT_RST;
    end else if (wr_tmo) begin
      if (sel_i[0]) begin
        timeout_r[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        timeout_r[15:8] <= dat_i[15:8];
      end
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  wire clr_rej  = wr_stat && sel_i[0] && dat_i[upwc_pkg::STAT_REJECT_BIT];
  wire clr_dis  = wr_stat && sel_i[0] && dat_i[upwc_pkg::STAT_DISCARD_BIT];
  wire dis_evt  = (state_r == upwc_pkg::ST_IDLE) && data_wake;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reject_r  <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      reject_r  <= ctrl_bad || (reject_r && !clr_rej);
      discard_r <= dis_evt || (discard_r && !clr_dis);
    end
  end

  // device-side outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_en_o    <= 1'b1;
      cts_on_o     <= 1'b1;
      rx_accept_o  <= 1'b1;
      tx_allow_o   <= 1'b1;
      active_o     <= 1'b1;
      deep_sleep_o <= 1'b0;
    end else begin
      port_en_o    <= port_nxt;
      cts_on_o     <= cts_nxt;
      rx_accept_o  <= acc_nxt;
      tx_allow_o   <= port_nxt && !in_deep;
      active_o     <= nxt_active;
      deep_sleep_o <= in_deep;
    end
  end

  // dtr changes keep their configured action in every mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtr_evt_o    <= 1'b0;
      dtr_evt_on_o <= 1'b0;
      dtr_action_o <= upwc_pkg::DACT_RST;
    end else begin
      dtr_evt_o    <= dtr_chg;
      dtr_evt_on_o <= lines_i.dtr_on;
      dtr_action_o <= dact_r;
    end
  end

  // read mux
  // unmapped offsets read as zero rather than aliasing a register
  wire [31:0] rd_ctrl = {18'h00000, dact_r, 3'h0, flow_en_r,
                         1'b0, variant_r, 1'b0, mode_r};
  wire [31:0] rd_tmo  = {16'h0000, timeout_r};
  wire [31:0] rd_stat = {26'h0000000, discard_r, reject_r,
                         state_r, cts_on_o, port_en_o};
  wire [31:0] rd_data = (adr_i == upwc_pkg::REG_CTRL)    ? rd_ctrl :
                        (adr_i == upwc_pkg::REG_TIMEOUT) ? rd_tmo  :
                        (adr_i == upwc_pkg::REG_STATUS)  ? rd_stat :
                        32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= bus_req;
      dat_o <= (bus_req && !we_i) ? rd_data : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// >>> sim/upwc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module upwc_checker (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire upwc_pkg::upwc_lines_t lines_i,
  input wire logic                  port_en_o,
  input wire logic                  cts_on_o,
  input wire logic                  rx_accept_o,
  input wire logic                  tx_allow_o,
  input wire logic                  active_o,
  input wire logic                  deep_sleep_o,
  input wire logic                  dtr_evt_o,
  input wire logic                  dtr_evt_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_dtr_evt_change: assert property ($changed(lines_i.dtr_on) |=> dtr_evt_o && dtr_evt_on_o == $past(lines_i.dtr_on))
    else $error("dtr change gave no event");
  a_dtr_evt_quiet: assert property ($stable(lines_i.dtr_on) |=> !dtr_evt_o)
    else $error("dtr event without change");
  a_deep_port_dead: assert property (deep_sleep_o |-> !port_en_o && !rx_accept_o && !tx_allow_o)
    else $error("port alive in deep sleep");
  a_tx_allow_gate: assert property (tx_allow_o == (port_en_o && !deep_sleep_o))
    else $error("tx allow disagrees with port state");
  a_cts_port_off: assert property (!cts_on_o |-> !port_en_o)
    else $error("cts off while port enabled");
  a_accept_awake: assert property (rx_accept_o |-> active_o && port_en_o)
    else $error("characters accepted before wake done");
endmodule
bind upwc_top upwc_checker upwc_checker_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .lines_i(lines_i), .port_en_o(port_en_o), .cts_on_o(cts_on_o),
  .rx_accept_o(rx_accept_o), .tx_allow_o(tx_allow_o), .active_o(active_o), .deep_sleep_o(deep_sleep_o),
  .dtr_evt_o(dtr_evt_o), .dtr_evt_on_o(dtr_evt_on_o));
`default_nettype wire

// >>> sim/upwc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module upwc_host_model #(
  parameter int unsigned GUARD = 20
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             dtr_i,
  input  wire logic             rts_i,
  input  wire logic             char_i,
  output upwc_pkg::upwc_lines_t lines_o
);
  logic [2:0]  bit_r;
  logic [15:0] guard_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_r   <= 3'h0;
      guard_r <= 16'h0;
    end else if (char_i && guard_r == 16'h0) begin
      bit_r   <= 3'h4;
      guard_r <= GUARD[15:0] + 16'h8;
    end else begin
      if (bit_r != 3'h0) bit_r <= bit_r - 3'h1;
      if (guard_r != 16'h0) guard_r <= guard_r - 16'h1;
    end
  end
  // start bit pulls txd low; line idles high between characters
  assign lines_o = '{dtr_on: dtr_i, rts_on: rts_i, txd: bit_r == 3'h0};
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int FR = 10;
  localparam int WK = 20;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        rxc = 1'b0, txp = 1'b0, deep = 1'b0, dtr = 1'b0, rts = 1'b0, chr = 1'b0;
  wire logic   ack_o, pen, cts, acc, txa, act, dsl, evt, evo;
  wire logic [31:0] dat_o;
  wire logic [1:0]  dact;
  wire upwc_pkg::upwc_lines_t lines;
  int          failures = 0, n_tests = 0, n;
  logic [31:0] rq[$];
  logic [31:0] x = 32'd79;
  logic [31:0] rej [4] = '{32'h23, 32'h102, 32'h5, 32'h50};
  upwc_host_model #(.GUARD(WK)) upwc_host_model_i (.clk_i(clk_i), .rst_i(rst_i), .dtr_i(dtr), .rts_i(rts),
    .char_i(chr), .lines_o(lines));
  upwc_top #(.FRAME_CYCLES(FR), .WAKE_CYCLES(WK)) upwc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .lines_i(lines), .rx_char_i(rxc), .tx_pending_i(txp), .deep_req_i(deep), .port_en_o(pen), .cts_on_o(cts),
    .rx_accept_o(acc), .tx_allow_o(txa), .active_o(act), .deep_sleep_o(dsl), .dtr_evt_o(evt),
    .dtr_evt_on_o(evo), .dtr_action_o(dact));
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] o();
    return {24'h0, pen, cts, acc, txa, act, dsl, evt, evo};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic drv(input int s, input logic v);
    @(posedge clk_i);
    case (s)
      0: dtr <= v;
      1: rts <= v;
      2: chr <= v;
      3: rxc <= v;
      4: txp <= v;
      default: deep <= v;
    endcase
  endtask
  task automatic wt(input int s, input logic v);
    n = 0;
    while ((s == 0 ? pen : s == 1 ? act : dsl) !== v && n < 1000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // read data is judged where it appears, against the oldest note
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) check(dat_o, rq.pop_front());
  initial begin
    #400000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h7d0);
    rd(4'h8, 32'h3);
    rd(4'hc, 32'h0);
    foreach (rej[i]) begin
      wb(1'b1, 4'h0, rej[i]);
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h13);
      wb(1'b1, 4'h8, 32'h10);
    end
    repeat (3) begin
      x = xs(x);
      wb(1'b1, 4'h4, x);
      rd(4'h4, {16'h0, x[15:0]});
    end
    drv(0, 1'b1);
    drv(1, 1'b1);
    tick(0);
    check(o(), 32'hfb);
    wb(1'b1, 4'h0, 32'h2113);
    rd(4'h0, 32'h2113);
    check({30'h0, dact}, 32'h2);
    drv(5, 1'b1);
    tick(30);
    check(o(), 32'hf9);
    drv(5, 1'b0);
    drv(0, 1'b0);
    tick(1);
    check(o(), 32'h02);
    drv(4, 1'b1);
    tick(2);
    check(o() & 32'hc0, 32'hc0);
    drv(4, 1'b0);
    wt(0, 1'b0);
    check(n < 5, 32'h1);
    drv(0, 1'b1);
    tick(1);
    check(o() & 32'hcb, 32'hc3);
    wt(1, 1'b1);
    check(n >= WK - 1 && n <= WK + 2, 32'h1);
    check(o() & 32'ha0, 32'ha0);
    wb(1'b1, 4'h4, 32'h3);
    for (int m = 1; m <= 4; m += 3) begin
      wb(1'b1, 4'h0, m);
      repeat (8) begin
        drv(3, 1'b1);
        drv(3, 1'b0);
        tick(15);
      end
      check(o() & 32'h80, 32'h80);
      wt(0, 1'b0);
      check(n + 15 >= 3 * FR - 3 && n + 15 <= 4 * FR + 3, 32'h1);
      drv(2, 1'b1);
      drv(2, 1'b0);
      tick(WK / 2);
      check(o() & 32'ha8, 32'h0);
      wt(1, 1'b1);
      check(n <= WK, 32'h1);
      check(o() & 32'ha0, 32'ha0);
      rd(4'h8, 32'h23);
      wb(1'b1, 4'h8, 32'h20);
    end
    wb(1'b1, 4'h0, 32'h2);
    drv(1, 1'b0);
    tick(1);
    check(o() & 32'hc0, 32'h40);
    tick(3);
    drv(2, 1'b1);
    drv(2, 1'b0);
    tick(WK + 10);
    check(o() & 32'ha8, 32'h0);
    drv(5, 1'b1);
    wt(2, 1'b1);
    drv(3, 1'b1);
    drv(3, 1'b0);
    tick(2);
    check(o(), 32'h45);
    drv(5, 1'b0);
    wt(2, 1'b0);
    check(n < 5, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
